// ===== hdl/imc_pkg.sv
// Constants shared by the I2C bus monitor and time-out status block.
// Assumes a 32-bit Avalon-MM register port and a 100 MHz function clock.
package imc_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [4:0] ADDR_STATUS  = 5'h00;
    localparam logic [4:0] ADDR_INT_EN  = 5'h04;
    localparam logic [4:0] ADDR_CONFIG  = 5'h08;
    localparam logic [4:0] ADDR_TIMEOUT = 5'h0C;
    localparam logic [4:0] ADDR_MON_RX  = 5'h10;
    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int BIT_MON_READY  = 6;
    localparam int BIT_MON_OVF    = 7;
    localparam int BIT_BUS_ACTIVE = 8;
    localparam int BIT_BUS_IDLE   = 9;
    localparam int BIT_EVT_TO     = 24;
    localparam int BIT_SCL_TO     = 25;
    // ****************************************
    // Configuration bits and reset values
    // ****************************************
    localparam int BIT_CFG_STRETCH = 0;
    localparam int BIT_CFG_TO_EN   = 1;
    localparam int TIMEOUT_W       = 16;
    localparam logic [31:0]          INT_EN_RESET  = 32'h0000_0000;
    localparam logic [1:0]           CONFIG_RESET  = 2'h0;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'hFFFF;
    localparam logic [31:0] W1C_MASK = 32'h0300_0280;
    localparam logic [31:0] IRQ_MASK = 32'h0300_02C0;
    localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
    localparam logic [3:0]  ACK_BIT       = 4'h8;
    typedef enum logic [1:0] {STR_FREE, STR_WAIT_LOW, STR_HOLD} imc_stretch_type;
endpackage

// ===== hdl/imc_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no multi-bit coherence.
`timescale 1ns/10ps
module imc_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,     // Function clock.
    input  wire logic         reset_n, // Asynchronous reset, active low.
    input  wire logic [W-1:0] async_i, // Levels from outside the domain.
    output logic      [W-1:0] sync_o   // Synchronised levels.
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule // imc_sync

// ===== hdl/imc_gap_counter.sv
// Interval counter that pulses once when a running interval exceeds a limit.
// Assumes restart and run come from logic on the same clock.
`timescale 1ns/10ps
module imc_gap_counter
    import imc_pkg::*;
(
    input  wire logic                 clk,      // Function clock.
    input  wire logic                 reset_n,  // Asynchronous reset, active low.
    input  wire logic                 run,      // Count this cycle.
    input  wire logic                 restart,  // Start a new interval.
    input  wire logic [TIMEOUT_W-1:0] limit,    // Allowed interval in cycles.
    output logic                      expired   // One-cycle pulse on overrun.
);
    logic [TIMEOUT_W:0] cnt_q, cnt_d;
    logic               exp_q, exp_d;

    // Saturating one above the limit keeps the pulse to one per interval.
    always_comb begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (run && cnt_q <= {1'b0, limit}) begin
            cnt_d = cnt_q + 1'b1;
            exp_d = (cnt_q == {1'b0, limit});
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expired = exp_q;
endmodule // imc_gap_counter

// ===== hdl/imc_monitor.sv
// I2C bus monitor with activity tracking, data capture and time-out flags.
// Assumes an Avalon-MM master on clk and an open-drain SCL/SDA bus outside.
//
// How it works
// - Overwriting unread captured data sets the overflow flag; write one clears it.
// - Overflow only without stretching; with stretching SCL is held low instead.
// - Bus-active bit 8 is one after a Start until a Stop; resets to zero.
// - Bus-went-idle bit 9 sets when the bus goes from active to inactive.
// - Idle flag with its enable bit set raises the interrupt output.
// - Writing one to bit 9 clears the idle flag until the next idle transition.
// - Event time-out bit 24 sets when the gap between bus events exceeds the limit while the bus is active.
// - Start, Stop and every SCL edge restart the event gap interval.
// - SCL held low never sets the event time-out flag.
// - SCL time-out bit 25 sets when SCL stays low beyond the limit.
// - Both time-out flags are sticky, reset to zero, cleared by writing one.
// - Monitor ready bit 6 shows waiting data; reading monitor data clears it unless a pending byte is loaded or a byte completes in that cycle.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module imc_monitor
    import imc_pkg::*;
(
    input  wire logic        clk,           // 100 MHz function clock.
    input  wire logic        reset_n,       // Asynchronous reset, active low.
    input  wire logic [4:0]  address,       // Avalon byte address.
    input  wire logic        read,          // Avalon read request.
    input  wire logic        write,         // Avalon write request.
    input  wire logic [31:0] writedata,     // Avalon write data.
    input  wire logic [3:0]  byteenable,    // Avalon byte lanes.
    output logic      [31:0] readdata,      // Avalon read data.
    output logic             waitrequest,   // Avalon wait request.
    output logic             irq,           // Level interrupt, active high.
    input  wire logic        scl_in,        // SCL pin level.
    output logic             scl_out,       // SCL drive value, always low.
    output logic             scl_oe,        // SCL drive enable, high to pull low.
    input  wire logic        sda_in         // SDA pin level.
);
    // ****************************************
    // Bus pin sampling
    // ****************************************
    logic [1:0] pins_s;
    logic       scl_s, sda_s, scl_p_q, sda_p_q;
    logic       scl_rise, scl_fall, start_det, stop_det;

    imc_sync #(.W(2)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .async_i ({scl_in, sda_in}),
        .sync_o  (pins_s)
    );

    assign scl_s     = pins_s[1];
    assign sda_s     = pins_s[0];
    assign scl_rise  = scl_s & ~scl_p_q;
    assign scl_fall  = ~scl_s & scl_p_q;
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // ****************************************
    // Avalon slave handshake
    // ****************************************
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        req, wr_ack, rd_ack;
    logic [31:0] wmask;

    // One wait state: the request is answered at the second edge it is held.
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign wr_ack      = write & ack_q;
    assign rd_ack      = read & ack_q;
    assign readdata    = rdata_q;
    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

    // ****************************************
    // Software registers and status
    // ****************************************
    logic [31:0]          int_en_q, int_en_d;
    logic [1:0]           cfg_q, cfg_d;
    logic [TIMEOUT_W-1:0] limit_q, limit_d;
    logic [31:0]          flags_q, flags_d;
    logic                 active_q, active_d;
    logic [7:0]           mon_data_q, mon_data_d;
    logic [7:0]           pend_q, pend_d;
    logic                 pend_v_q, pend_v_d;
    logic [7:0]           shift_q, shift_d;
    logic [3:0]           bit_q, bit_d;
    imc_stretch_type      str_q, str_d;
    logic                 evt_exp, low_exp, stretch, to_en;
    logic                 byte_done, data_read;
    logic [31:0]          status, set_v, clr_v;

    assign stretch   = cfg_q[BIT_CFG_STRETCH];
    assign to_en     = cfg_q[BIT_CFG_TO_EN];
    assign data_read = rd_ack && address == ADDR_MON_RX;
    assign byte_done = scl_rise && bit_q == LAST_DATA_BIT && active_q;

    // Reserved bits read as zero; bus-active is a live level.
    always_comb begin
        status                 = flags_q & (W1C_MASK | 32'h0000_0040);
        status[BIT_BUS_ACTIVE] = active_q;
    end

    // ****************************************
    // Time-out counters
    // ****************************************
    imc_gap_counter u_evt_gap (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (to_en & active_q & scl_s),
        .restart (start_det | stop_det | scl_rise | scl_fall),
        .limit   (limit_q),
        .expired (evt_exp)
    );

    imc_gap_counter u_scl_low (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (to_en & ~scl_s),
        .restart (scl_rise),
        .limit   (limit_q),
        .expired (low_exp)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        ack_d      = req & ~ack_q;
        rdata_d    = rdata_q;
        int_en_d   = int_en_q;
        cfg_d      = cfg_q;
        limit_d    = limit_q;
        active_d   = active_q;
        mon_data_d = mon_data_q;
        pend_d     = pend_q;
        pend_v_d   = pend_v_q;
        shift_d    = shift_q;
        bit_d      = bit_q;
        str_d      = str_q;
        set_v      = '0;
        clr_v      = '0;

        // Read data is prepared in the wait cycle and stands at the answer.
        if (read && !ack_q) begin
            case (address)
                ADDR_STATUS:  rdata_d = status;
                ADDR_INT_EN:  rdata_d = int_en_q & IRQ_MASK;
                ADDR_CONFIG:  rdata_d = {30'h0, cfg_q};
                ADDR_TIMEOUT: rdata_d = {16'h0, limit_q};
                ADDR_MON_RX:  rdata_d = {24'h0, mon_data_q};
                default:      rdata_d = 32'h0000_0000;
            endcase
        end

        if (wr_ack) begin
            case (address)
                ADDR_STATUS:  clr_v = writedata & wmask & W1C_MASK;
                ADDR_INT_EN:  int_en_d = (int_en_q & ~wmask) | (writedata & wmask & IRQ_MASK);
                ADDR_CONFIG:  begin
                    if (byteenable[0]) begin
                        cfg_d = writedata[1:0];
                    end
                end
                ADDR_TIMEOUT: limit_d = (limit_q & ~wmask[15:0]) | (writedata[15:0] & wmask[15:0]);
                default:      ;
            endcase
        end

        // Bus activity tracking.
        if (start_det) begin
            active_d = 1'b1;
        end else if (stop_det) begin
            active_d = 1'b0;
        end
        set_v[BIT_BUS_IDLE] = active_q & ~active_d;
        set_v[BIT_EVT_TO]   = evt_exp;
        set_v[BIT_SCL_TO]   = low_exp;

        // Byte capture: eight data bits, then the acknowledge bit is skipped.
        if (start_det) begin
            bit_d = 4'h0;
        end else if (scl_rise && active_q) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_d   = (bit_q == ACK_BIT) ? 4'h0 : bit_q + 4'h1;
        end

        if (data_read) begin
            clr_v[BIT_MON_READY] = 1'b1;
            if (pend_v_q) begin
                mon_data_d = pend_q;
                pend_v_d   = 1'b0;
                set_v[BIT_MON_READY] = 1'b1;
            end
        end

        if (byte_done) begin
            if (flags_q[BIT_MON_READY] && !data_read && stretch) begin
                pend_d   = {shift_q[6:0], sda_s};
                pend_v_d = 1'b1;
            end else begin
                mon_data_d           = {shift_q[6:0], sda_s};
                set_v[BIT_MON_READY] = 1'b1;
                set_v[BIT_MON_OVF]   = flags_q[BIT_MON_READY] & ~data_read;
            end
        end

        // Stretching holds SCL low while a second byte waits for the reader.
        case (str_q)
            STR_FREE:     if (pend_v_d) str_d = STR_WAIT_LOW;
            STR_WAIT_LOW: begin
                if (!pend_v_d) begin
                    str_d = STR_FREE;
                end else if (scl_fall) begin
                    str_d = STR_HOLD;
                end
            end
            STR_HOLD:     if (!pend_v_d) str_d = STR_FREE;
            default:      str_d = STR_FREE;
        endcase
        if (stop_det) begin
            bit_d = 4'h0;
        end

        // A set in the same cycle as its clear wins.
        flags_d = ((flags_q & ~clr_v) | set_v) & (W1C_MASK | 32'h0000_0040);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            ack_q      <= 1'b0;
            rdata_q    <= '0;
            int_en_q   <= INT_EN_RESET;
            cfg_q      <= CONFIG_RESET;
            limit_q    <= TIMEOUT_RESET;
            flags_q    <= '0;
            active_q   <= 1'b0;
            mon_data_q <= '0;
            pend_q     <= '0;
            pend_v_q   <= 1'b0;
            shift_q    <= '0;
            bit_q      <= '0;
            str_q      <= STR_FREE;
        end else begin
            scl_p_q    <= scl_s;
            sda_p_q    <= sda_s;
            ack_q      <= ack_d;
            rdata_q    <= rdata_d;
            int_en_q   <= int_en_d;
            cfg_q      <= cfg_d;
            limit_q    <= limit_d;
            flags_q    <= flags_d;
            active_q   <= active_d;
            mon_data_q <= mon_data_d;
            pend_q     <= pend_d;
            pend_v_q   <= pend_v_d;
            shift_q    <= shift_d;
            bit_q      <= bit_d;
            str_q      <= str_d;
        end
    end

    assign irq     = |(flags_q & int_en_q & IRQ_MASK);
    assign scl_out = 1'b0;
    assign scl_oe  = (str_q == STR_HOLD);

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_bus_start;
        start_det;
    endsequence

    sequence s_bus_stop;
        stop_det && !start_det;
    endsequence

    a_active_start: assert property (@(posedge clk) disable iff (!reset_n)
        s_bus_start |=> status[BIT_BUS_ACTIVE])
        else $error("Bus-active not set after a Start.");

    a_active_stop: assert property (@(posedge clk) disable iff (!reset_n)
        s_bus_stop |=> !status[BIT_BUS_ACTIVE])
        else $error("Bus-active not cleared after a Stop.");

    a_idle_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(active_q) |-> flags_q[BIT_BUS_IDLE])
        else $error("Idle flag not set when the bus went inactive.");

    a_idle_irq: assert property (@(posedge clk) disable iff (!reset_n)
        (flags_q[BIT_BUS_IDLE] && int_en_q[BIT_BUS_IDLE]) |-> irq)
        else $error("Enabled idle flag did not raise the interrupt.");

    a_idle_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_ack && address == ADDR_STATUS && writedata[BIT_BUS_IDLE] && byteenable[1]
         && !(active_q && stop_det && !start_det)) |=> !flags_q[BIT_BUS_IDLE])
        else $error("Idle flag not cleared by writing one.");

    a_evt_not_low: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(flags_q[BIT_EVT_TO]) |-> $past(scl_s, 2))
        else $error("Event time-out raised while SCL was low.");

    a_scl_low_to: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(flags_q[BIT_SCL_TO]) |-> !$past(scl_s, 2))
        else $error("SCL time-out raised while SCL was high.");

    a_ovf_no_str: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(flags_q[BIT_MON_OVF]) |-> !$past(stretch))
        else $error("Overflow raised with stretching enabled.");

    a_ready_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (data_read && !byte_done && !pend_v_q) |=> !flags_q[BIT_MON_READY])
        else $error("Ready flag not cleared by reading monitor data.");

    a_one_wait: assert property (@(posedge clk) disable iff (!reset_n)
        (req && waitrequest) |=> (req ##0 !waitrequest) or !req)
        else $error("Request not answered after one wait state.");

    sequence s_byte_overrun;
        byte_done && flags_q[BIT_MON_READY] && !data_read && !stretch;
    endsequence

    a_ovf_set: assert property (@(posedge clk) disable iff (!reset_n)
        s_byte_overrun |=> flags_q[BIT_MON_OVF])
        else $error("Overflow not set when unread data was overwritten.");

    a_stretch_free: assert property (@(posedge clk) disable iff (!reset_n)
        (data_read && pend_v_q) |=> !scl_oe)
        else $error("SCL still held after the pending byte was taken.");

    a_evt_set: assert property (@(posedge clk) disable iff (!reset_n)
        evt_exp |=> flags_q[BIT_EVT_TO])
        else $error("Event time-out pulse did not set its flag.");

    a_low_set: assert property (@(posedge clk) disable iff (!reset_n)
        low_exp |=> flags_q[BIT_SCL_TO])
        else $error("SCL time-out pulse did not set its flag.");

    a_evt_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        (flags_q[BIT_EVT_TO] && !(wr_ack && address == ADDR_STATUS
         && writedata[BIT_EVT_TO] && byteenable[3])) |=> flags_q[BIT_EVT_TO])
        else $error("Event time-out flag dropped without a clear.");

    a_byte_ready: assert property (@(posedge clk) disable iff (!reset_n)
        byte_done |=> flags_q[BIT_MON_READY])
        else $error("Ready flag not set after a captured byte.");
endmodule // imc_monitor

// ===== verification/imc_i2c_master.sv
// Behavioural I2C bus master that frames Starts, bytes and Stops on SCL and SDA.
// Assumes open-drain wires with pull-ups resolved in the bench from every drive.
`timescale 1ns/10ps
module imc_i2c_master (
    input  wire logic clk,       // Function clock that paces the bus phases.
    input  wire logic scl_line,  // Resolved SCL wire level.
    output logic      scl_drv,   // One releases SCL, zero pulls it low.
    output logic      sda_drv,   // One releases SDA, zero pulls it low.
    output logic      timed_out  // A stretched clock was never released.
);
    localparam int HALF = 8; // Eight cycles of 10 ns give a 160 ns SCL period.

    initial begin
        scl_drv   = 1'b1;
        sda_drv   = 1'b1;
        timed_out = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_cond();
        sda_drv <= 1'b0;
        wait_cyc(HALF);
    endtask

    // A released clock may be held low by the monitor, so the high phase only
    // begins once the wire itself is seen high.
    task automatic send_bit(input logic b);
        int guard;
        guard = 0;
        scl_drv <= 1'b0;
        sda_drv <= b;
        wait_cyc(HALF);
        scl_drv <= 1'b1;
        do begin
            @(negedge clk);
            guard++;
        end while (scl_line !== 1'b1 && guard < 2000);
        if (guard >= 2000) timed_out <= 1'b1;
        @(posedge clk);
        wait_cyc(HALF - 1);
    endtask

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) send_bit(b[i]);
        send_bit(1'b1);
    endtask

    task automatic stop_cond();
        scl_drv <= 1'b0;
        sda_drv <= 1'b0;
        wait_cyc(HALF);
        scl_drv <= 1'b1;
        wait_cyc(HALF);
        sda_drv <= 1'b1;
        wait_cyc(HALF);
    endtask

    task automatic hold_low(input int n);
        scl_drv <= 1'b0;
        wait_cyc(n);
        scl_drv <= 1'b1;
        wait_cyc(HALF);
    endtask
endmodule // imc_i2c_master

// ===== verification/tb_top.sv
// Self-checking bench for the bus monitor and time-out status block.
// Assumes the bus master model drives SCL and SDA; software is an Avalon-MM master here.
`timescale 1ns/10ps
module tb_top;
    import imc_pkg::*;
    logic        clk, reset_n, read, write, waitrequest, irq;
    logic        scl_out, scl_oe, scl_drv, sda_drv, bus_hung, scl_line;
    logic [4:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [7:0]  b1, b2;
    int          n_mismatch, n_checks, guard;

    assign scl_line = scl_drv & ~scl_oe;

    imc_monitor DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .scl_in(scl_line), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_drv));
    imc_i2c_master bus_master (.clk(clk), .scl_line(scl_line), .scl_drv(scl_drv),
        .sda_drv(sda_drv), .timed_out(bus_hung));

    always #5 clk = ~clk;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] exp_st(input logic rdy, ovf, act, idle, eto, sto);
        exp_st = 32'h0000_0000;
        exp_st[BIT_MON_READY]  = rdy;
        exp_st[BIT_MON_OVF]    = ovf;
        exp_st[BIT_BUS_ACTIVE] = act;
        exp_st[BIT_BUS_IDLE]   = idle;
        exp_st[BIT_EVT_TO]     = eto;
        exp_st[BIT_SCL_TO]     = sto;
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    // The request is held until waitrequest is sampled low at a rising edge, where read
    // data are taken; an idle cycle follows so a strobe never rises again at once.
    task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int g;
        g = 0;
        address   <= a;
        writedata <= d;
        read      <= ~wr;
        write     <= wr;
        do begin
            @(posedge clk);
            g++;
        end while (waitrequest !== 1'b0 && g < 100);
        if (g >= 100) chk("waitrequest", 32'h0, 32'h1);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string name);
        av_xfer(1'b0, a, 32'h0000_0000, rd);
        chk(name, exp, rd);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        av_xfer(1'b1, a, d, rd);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 1'b0; reset_n = 1'b0; read = 1'b0; write = 1'b0;
        address = 5'h00; writedata = 32'h0000_0000; n_mismatch = 0; n_checks = 0;
        void'($urandom(30103));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_chk(ADDR_STATUS, 32'h0000_0000, "status_reset");
        rd_chk(ADDR_INT_EN, INT_EN_RESET, "int_en_reset");
        rd_chk(ADDR_CONFIG, 32'h0000_0000, "config_reset");
        rd_chk(ADDR_TIMEOUT, {16'h0000, TIMEOUT_RESET}, "timeout_reset");
        wr(5'h14, 32'hFFFF_FFFF);
        rd_chk(5'h14, 32'h0000_0000, "unmapped");
        $display("test reset_values done");

        wr(ADDR_INT_EN, 32'h0000_0200);
        bus_master.start_cond();
        rd_chk(ADDR_STATUS, exp_st(0, 0, 1, 0, 0, 0), "bus_active");
        chk("irq_busy", 32'h0, {31'h0, irq});
        bus_master.stop_cond();
        rd_chk(ADDR_STATUS, exp_st(0, 0, 0, 1, 0, 0), "went_idle");
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(ADDR_INT_EN, 32'h0000_0000);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(ADDR_STATUS, 32'h0000_0000);
        rd_chk(ADDR_STATUS, exp_st(0, 0, 0, 1, 0, 0), "idle_write_zero");
        wr(ADDR_INT_EN, 32'h0000_0200);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        wr(ADDR_STATUS, 32'h0000_0200);
        rd_chk(ADDR_STATUS, 32'h0000_0000, "idle_cleared");
        chk("irq_cleared", 32'h0, {31'h0, irq});
        $display("test active_idle done");

        b1 = 8'($urandom());
        b2 = b1 ^ (8'h01 | 8'($urandom()));
        bus_master.start_cond();
        bus_master.send_byte(b1);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 0), "ready_set");
        rd_chk(ADDR_MON_RX, {24'h0, b1}, "rx_byte");
        rd_chk(ADDR_STATUS, exp_st(0, 0, 1, 0, 0, 0), "ready_cleared");
        bus_master.send_byte(b1);
        bus_master.send_byte(b2);
        rd_chk(ADDR_STATUS, exp_st(1, 1, 1, 0, 0, 0), "overrun");
        rd_chk(ADDR_MON_RX, {24'h0, b2}, "rx_overwritten");
        wr(ADDR_STATUS, 32'h0000_0200);
        rd_chk(ADDR_STATUS, exp_st(0, 1, 1, 0, 0, 0), "ovf_write_zero");
        wr(ADDR_STATUS, 32'h0000_0080);
        rd_chk(ADDR_STATUS, exp_st(0, 0, 1, 0, 0, 0), "ovf_cleared");
        bus_master.stop_cond();
        wr(ADDR_STATUS, W1C_MASK);
        $display("test overrun done");

        wr(ADDR_CONFIG, 32'h0000_0001);
        bus_master.start_cond();
        bus_master.send_byte(b1);
        fork
            bus_master.send_byte(b2);
            begin
                guard = 0;
                do begin
                    @(negedge clk);
                    guard++;
                end while (scl_oe !== 1'b1 && guard < 400);
                @(posedge clk);
                chk("stretch_hold", 32'h1, {31'h0, scl_oe});
                chk("scl_drive_low", 32'h0, {31'h0, scl_out});
                rd_chk(ADDR_MON_RX, {24'h0, b1}, "rx_held_first");
            end
        join
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 0), "no_overrun");
        rd_chk(ADDR_MON_RX, {24'h0, b2}, "rx_pending");
        chk("stretch_released", 32'h0, {31'h0, bus_hung});
        bus_master.stop_cond();
        wr(ADDR_STATUS, W1C_MASK);
        $display("test stretch done");

        // The limit is kept well above the 8-cycle bus phases and the register
        // accesses that follow a bus event, so only the long gaps can expire.
        wr(ADDR_TIMEOUT, 32'h0000_0028);
        wr(ADDR_CONFIG, 32'h0000_0002);
        bus_master.start_cond();
        bus_master.send_byte(8'($urandom()));
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 0), "fast_edges");
        repeat (100) @(posedge clk);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 1, 0), "event_gap");
        wr(ADDR_STATUS, 32'h0100_0000);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 0), "event_cleared");
        bus_master.hold_low(100);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 1), "clock_low");
        wr(ADDR_STATUS, 32'h0100_0000);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 1), "clock_low_kept");
        wr(ADDR_STATUS, 32'h0200_0000);
        rd_chk(ADDR_STATUS, exp_st(1, 0, 1, 0, 0, 0), "clock_low_cleared");
        bus_master.stop_cond();
        $display("test timeouts done");
        test_done();
    end
endmodule // tb_top
